// ==== core/acc_cal_ctrl.sv ====
// calibration and interleave input-select control behind the serial port
// Function
// - interleaved mode routes input A for code 1, B for code 2; 0,3 reserved.
// - input select acts only while interleaved mode is on.
// - calibration runs while the enable bit is high; it resets to one.
// - enable bit low holds the calibration logic in reset.
// - enable bit low also resets encoder and output clock dividers.
// - setting enable again re-runs calibration with the new settings.
// - config bit 3 enables background offset trim, needs background trim.
// - config bit 2 enables foreground offset trim, needs foreground trim.
// - config bit 1 enables background calibration; resets to zero.
// - config bit 0 always clears values, then runs foreground when set.
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_cal_ctrl
  import acc_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic SPI_SCLK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_SDI_I,
  input wire logic INTERLEAVE_EN_I,
  output logic SPI_SDO_O,
  output logic SPI_SDO_OE_O,
  output logic INTERLEAVE_ON_INPUT_A_O,
  output logic INTERLEAVE_ON_INPUT_B_O,
  output logic CAL_RUN_O,
  output logic CAL_LOGIC_RST_O,
  output logic CLK_DIV_RST_O,
  output logic CAL_START_O,
  output logic CAL_VALUES_CLR_O,
  output logic FOREGROUND_TRIM_ON_O,
  output logic BACKGROUND_TRIM_ON_O,
  output logic FOREGROUND_OFFSET_TRIM_ON_O,
  output logic BACKGROUND_OFFSET_TRIM_ON_O
);

  // three-stage synchronisers for the serial pins: sclk, cs_n, sdi
  logic [2:0] s1_ff, s2_ff, s3_ff;
  logic [2:0] pin_ff;
  logic sclk_prev_ff;
  logic [4:0] cnt_ff;
  logic [23:0] shin_ff;
  logic [6:0] shout_ff;
  logic is_read_ff;
  acc_sel_t input_sel_ff;
  logic cal_enable_ff;
  logic [3:0] cal_cfg_ff;
  logic cal_en_prev_ff;
  logic [23:0] nxt_shin;
  logic [`ACC_ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic sclk_rise, sclk_fall, cs_active;

  // read mux; unmapped and reserved bits answer zero
  function automatic logic [7:0] read_reg(input logic [`ACC_ADDR_W-1:0] a,
                                          input acc_sel_t sel,
                                          input logic en,
                                          input logic [3:0] cfg);
    logic [7:0] d;
    d = 8'h00;
    if (a == `ACC_OFS_INPUT_SELECT) begin
      d = {6'h00, sel};
    end else if (a == `ACC_OFS_CAL_ENABLE) begin
      d = {7'h00, en};
    end else if (a == `ACC_OFS_CAL_CONFIG0) begin
      d = {4'h0, cfg};
    end
    return d;
  endfunction

  // sync chain; stage one feeds stage two only
  // reset to the idle pin levels (sclk low, cs_n high, sdi low) so that
  // no false clock edge appears after reset
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s1_ff <= 3'h2;
      s2_ff <= 3'h2;
      s3_ff <= 3'h2;
    end else if (CE_I) begin
      s1_ff <= {SPI_SDI_I, SPI_CS_N_I, SPI_SCLK_I};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // filtered pin level: a bit changes only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_filt
      always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          pin_ff[g] <= (g == 1) ? 1'b1 : 1'b0;
        end else if (CE_I && (s2_ff[g] == s3_ff[g])) begin
          pin_ff[g] <= s3_ff[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sclk_prev_ff <= 1'b0;
    end else if (CE_I) begin
      sclk_prev_ff <= pin_ff[0];
    end
  end

  assign cs_active = ~pin_ff[1];
  assign sclk_rise = cs_active & pin_ff[0] & ~sclk_prev_ff;
  assign sclk_fall = cs_active & ~pin_ff[0] & sclk_prev_ff;
  assign nxt_shin = {shin_ff[22:0], pin_ff[2]};
  assign rd_addr = shin_ff[`ACC_ADDR_W-1:0];
  assign rd_data = read_reg(rd_addr, input_sel_ff, cal_enable_ff, cal_cfg_ff);

  // bit counter and input shifter; a frame restarts whenever cs is released
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_ff <= 5'h00;
      shin_ff <= 24'h000000;
      is_read_ff <= 1'b0;
    end else if (CE_I) begin
      if (!cs_active) begin
        cnt_ff <= 5'h00;
        is_read_ff <= 1'b0;
      end else if (sclk_rise && cnt_ff != `ACC_FRAME_BITS) begin
        cnt_ff <= cnt_ff + 5'h01;
        shin_ff <= nxt_shin;
        if (cnt_ff == 5'h00) begin
          is_read_ff <= pin_ff[2]; // first bit high means read
        end
      end
    end
  end

  // read data leaves msb first, changing on falling clock edges
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SPI_SDO_O <= 1'b0;
      SPI_SDO_OE_O <= 1'b0;
      shout_ff <= 7'h00;
    end else if (CE_I) begin
      SPI_SDO_OE_O <= cs_active & is_read_ff & (cnt_ff >= `ACC_HEADER_BITS);
      if (!cs_active) begin
        SPI_SDO_O <= 1'b0;
      end else if (sclk_fall && is_read_ff) begin
        if (cnt_ff == `ACC_HEADER_BITS) begin
          SPI_SDO_O <= rd_data[7];
          shout_ff <= rd_data[6:0];
        end else begin
          SPI_SDO_O <= shout_ff[6];
          shout_ff <= {shout_ff[5:0], 1'b0};
        end
      end
    end
  end

  // register writes commit on the last rising edge of a write frame;
  // configuration is stored whatever the enable state, since keeping the
  // enable low during the write is the host's duty
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      input_sel_ff <= acc_sel_t'(`ACC_RST_INPUT_SELECT);
      cal_enable_ff <= `ACC_RST_CAL_ENABLE;
      cal_cfg_ff <= `ACC_RST_CAL_CONFIG0;
    end else if (CE_I && sclk_rise && !is_read_ff &&
                 cnt_ff == `ACC_FRAME_BITS - 5'h01) begin
      if (nxt_shin[22:8] == `ACC_OFS_INPUT_SELECT) begin
        input_sel_ff <= acc_sel_t'(nxt_shin[1:0]);
      end
      if (nxt_shin[22:8] == `ACC_OFS_CAL_ENABLE) begin
        cal_enable_ff <= nxt_shin[0];
      end
      if (nxt_shin[22:8] == `ACC_OFS_CAL_CONFIG0) begin
        cal_cfg_ff <= nxt_shin[3:0]; // upper bits dropped
      end
    end
  end

  // input routing only in interleaved mode; reserved codes route nothing
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      INTERLEAVE_ON_INPUT_A_O <= 1'b0;
      INTERLEAVE_ON_INPUT_B_O <= 1'b0;
    end else if (CE_I) begin
      INTERLEAVE_ON_INPUT_A_O <= INTERLEAVE_EN_I &&
                                 input_sel_ff == ACC_SEL_INPUT_A;
      INTERLEAVE_ON_INPUT_B_O <= INTERLEAVE_EN_I &&
                                 input_sel_ff == ACC_SEL_INPUT_B;
    end
  end

  // run/reset levels and the start pulse on each enable rising edge;
  // prev resets low so calibration also starts right after reset
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cal_en_prev_ff <= 1'b0;
      CAL_RUN_O <= 1'b0;
      CAL_LOGIC_RST_O <= 1'b1;
      CLK_DIV_RST_O <= 1'b1;
      CAL_START_O <= 1'b0;
      CAL_VALUES_CLR_O <= 1'b0;
    end else if (CE_I) begin
      cal_en_prev_ff <= cal_enable_ff;
      CAL_RUN_O <= cal_enable_ff;
      CAL_LOGIC_RST_O <= ~cal_enable_ff;
      CLK_DIV_RST_O <= ~cal_enable_ff;
      CAL_START_O <= cal_enable_ff & ~cal_en_prev_ff;
      CAL_VALUES_CLR_O <= cal_enable_ff & ~cal_en_prev_ff;
    end
  end

  // trim enables, each offset trim gated by its parent mode
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FOREGROUND_TRIM_ON_O <= 1'b0;
      BACKGROUND_TRIM_ON_O <= 1'b0;
      FOREGROUND_OFFSET_TRIM_ON_O <= 1'b0;
      BACKGROUND_OFFSET_TRIM_ON_O <= 1'b0;
    end else if (CE_I) begin
      FOREGROUND_TRIM_ON_O <= cal_enable_ff &
                              cal_cfg_ff[`ACC_BIT_FG];
      BACKGROUND_TRIM_ON_O <= cal_enable_ff &
                              cal_cfg_ff[`ACC_BIT_BG];
      FOREGROUND_OFFSET_TRIM_ON_O <= cal_enable_ff & cal_cfg_ff[`ACC_BIT_FG] &
                                     cal_cfg_ff[`ACC_BIT_FG_OFS];
      BACKGROUND_OFFSET_TRIM_ON_O <= cal_enable_ff & cal_cfg_ff[`ACC_BIT_BG] &
                                     cal_cfg_ff[`ACC_BIT_BG_OFS];
    end
  end

endmodule

// ==== core/acc_consts.svh ====
// register offsets, field positions, reset values and frame counts
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_ADDR_W 15
`define ACC_DATA_W 8
`define ACC_OFS_INPUT_SELECT 15'h0060
`define ACC_OFS_CAL_ENABLE 15'h0061
`define ACC_OFS_CAL_CONFIG0 15'h0062
`define ACC_RST_INPUT_SELECT 2'h1
`define ACC_RST_CAL_ENABLE 1'h1
`define ACC_RST_CAL_CONFIG0 4'h1
`define ACC_BIT_FG 0
`define ACC_BIT_BG 1
`define ACC_BIT_FG_OFS 2
`define ACC_BIT_BG_OFS 3
`define ACC_FRAME_BITS 5'h18
`define ACC_HEADER_BITS 5'h10
`define ACC_CMD_BIT 23
`endif

// ==== core/acc_pkg.sv ====
// types shared by the calibration control block
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_SEL_RSVD0 = 2'b00,
    ACC_SEL_INPUT_A = 2'b01,
    ACC_SEL_INPUT_B = 2'b10,
    ACC_SEL_RSVD3 = 2'b11
  } acc_sel_t;
endpackage

// ==== tb/acc_cal_chk.sv ====
// port assertions for the calibration control block
`timescale 1ns/1ps
module acc_cal_chk (
  input logic REF_CLK_I,
  input logic RST_I,
  input logic INTERLEAVE_EN_I,
  input logic INTERLEAVE_ON_INPUT_A_O,
  input logic INTERLEAVE_ON_INPUT_B_O,
  input logic CAL_RUN_O,
  input logic CAL_LOGIC_RST_O,
  input logic CLK_DIV_RST_O,
  input logic CAL_START_O,
  input logic CAL_VALUES_CLR_O,
  input logic FOREGROUND_TRIM_ON_O,
  input logic BACKGROUND_TRIM_ON_O,
  input logic FOREGROUND_OFFSET_TRIM_ON_O,
  input logic BACKGROUND_OFFSET_TRIM_ON_O
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  AST_EXCL: assert property (
    !(INTERLEAVE_ON_INPUT_A_O && INTERLEAVE_ON_INPUT_B_O))
    else $error("both inputs routed");
  AST_DES: assert property (
    !INTERLEAVE_EN_I |=> !(INTERLEAVE_ON_INPUT_A_O || INTERLEAVE_ON_INPUT_B_O))
    else $error("route while interleave off");
  AST_HOLD: assert property (CAL_LOGIC_RST_O != CAL_RUN_O)
    else $error("calibration reset not inverse of run");
  AST_DIV: assert property (CLK_DIV_RST_O == CAL_LOGIC_RST_O)
    else $error("divider reset differs from calibration reset");
  AST_START: assert property (CAL_START_O == $rose(CAL_RUN_O))
    else $error("start pulse not on run rise");
  AST_CLR: assert property (CAL_VALUES_CLR_O == CAL_START_O)
    else $error("values clear apart from start");
  AST_BGO: assert property (
    BACKGROUND_OFFSET_TRIM_ON_O |-> BACKGROUND_TRIM_ON_O)
    else $error("background offset without background");
  AST_FGO: assert property (
    FOREGROUND_OFFSET_TRIM_ON_O |-> FOREGROUND_TRIM_ON_O)
    else $error("foreground offset without foreground");
  AST_OFF: assert property (
    !CAL_RUN_O |-> !(FOREGROUND_TRIM_ON_O || BACKGROUND_TRIM_ON_O))
    else $error("trim on while calibration stopped");
  cover property (CAL_START_O);
  cover property (INTERLEAVE_ON_INPUT_A_O);
  cover property (INTERLEAVE_ON_INPUT_B_O);
endmodule
bind acc_cal_ctrl acc_cal_chk i_chk (.REF_CLK_I, .RST_I, .INTERLEAVE_EN_I,
  .INTERLEAVE_ON_INPUT_A_O, .INTERLEAVE_ON_INPUT_B_O, .CAL_RUN_O,
  .CAL_LOGIC_RST_O, .CLK_DIV_RST_O, .CAL_START_O, .CAL_VALUES_CLR_O,
  .FOREGROUND_TRIM_ON_O, .BACKGROUND_TRIM_ON_O,
  .FOREGROUND_OFFSET_TRIM_ON_O, .BACKGROUND_OFFSET_TRIM_ON_O);

// ==== tb/acc_cal_ctrl_tb_top.sv ====
// self-checking bench for the calibration control block
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_cal_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic sdi = 1'b0;
  logic des = 1'b0;
  logic sdo, oe, on_a, on_b, run, crst, drst, go, vclr, fg, bg, fgo, bgo;
  logic [7:0] rd;
  logic oe_all;
  logic ce = 1'b1;
  int n_mismatch = 0;
  int compares = 0;
  int n_start = 0;
  int n_clr = 0;
  // clock enable is driven by the bench so that a freeze can be checked
  acc_cal_ctrl i_dut (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce),
    .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n), .SPI_SDI_I(sdi),
    .INTERLEAVE_EN_I(des), .SPI_SDO_O(sdo), .SPI_SDO_OE_O(oe),
    .INTERLEAVE_ON_INPUT_A_O(on_a), .INTERLEAVE_ON_INPUT_B_O(on_b),
    .CAL_RUN_O(run), .CAL_LOGIC_RST_O(crst), .CLK_DIV_RST_O(drst),
    .CAL_START_O(go), .CAL_VALUES_CLR_O(vclr), .FOREGROUND_TRIM_ON_O(fg),
    .BACKGROUND_TRIM_ON_O(bg), .FOREGROUND_OFFSET_TRIM_ON_O(fgo),
    .BACKGROUND_OFFSET_TRIM_ON_O(bgo));
  initial begin
    forever #4 clk = ~clk;
  end
  // start pulses last one cycle, so count them at every edge
  always @(posedge clk) begin
    if (go === 1'b1) n_start++;
    if (vclr === 1'b1) n_clr++;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // six clocks per phase leaves margin over the 3-4 clock pin filter
  task automatic xfer(input logic [23:0] f);
    oe_all = 1'b1;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk);
      cs_n <= 1'b0;
      sdi <= f[i];
      repeat (6) @(posedge clk);
      sclk <= 1'b1;
      if (i < 8) begin
        rd[i] = sdo;
        oe_all = oe_all & oe;
      end
      repeat (6) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    xfer({1'b0, a, d});
    chk("sdo enable in write", 8'h00, {7'h0, oe_all});
  endtask
  task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
    xfer({1'b1, a, 8'h00});
    chk("read", e, rd);
    chk("sdo enable in read", 8'h01, {7'h0, oe_all});
    chk("sdo enable idle", 8'h00, {7'h0, oe});
  endtask
  task automatic t_reset;
    chk("run", 8'h01, {7'h0, run});
    chk("trims", 8'h01, {4'h0, bgo, fgo, bg, fg});
    chk("starts", 8'h01, 8'(n_start));
    chk("clears", 8'h01, 8'(n_clr));
    rdchk(`ACC_OFS_CAL_ENABLE, 8'h01);
    rdchk(`ACC_OFS_CAL_CONFIG0, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_sel;
    des <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(`ACC_OFS_INPUT_SELECT, 8'(c));
      chk("route", {6'h0, c == 2, c == 1}, {6'h0, on_b, on_a});
    end
    wr(`ACC_OFS_INPUT_SELECT, 8'hfd);
    rdchk(`ACC_OFS_INPUT_SELECT, 8'h01);
    des <= 1'b0;
    repeat (3) @(posedge clk);
    chk("route", 8'h00, {6'h0, on_b, on_a});
    // with the clock enable low the routing must not follow the pin
    ce <= 1'b0;
    des <= 1'b1;
    repeat (3) @(posedge clk);
    chk("frozen route", 8'h00, {6'h0, on_b, on_a});
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk("route", 8'h01, {6'h0, on_b, on_a});
    des <= 1'b0;
    repeat (3) @(posedge clk);
    $display("test select done");
  endtask
  task automatic t_cal;
    logic [7:0] cf [2] = '{8'hfe, 8'h05};
    logic [7:0] rb [2] = '{8'h0e, 8'h05};
    logic [7:0] tr [2] = '{8'h0a, 8'h05};
    int s0;
    int c0;
    for (int k = 0; k < 2; k++) begin
      wr(`ACC_OFS_CAL_ENABLE, 8'h00);
      chk("hold", 8'h03, {6'h0, crst, drst});
      wr(`ACC_OFS_CAL_CONFIG0, cf[k]);
      rdchk(`ACC_OFS_CAL_CONFIG0, rb[k]);
      s0 = n_start;
      c0 = n_clr;
      wr(`ACC_OFS_CAL_ENABLE, 8'h01);
      chk("starts", 8'(s0 + 1), 8'(n_start));
      chk("clears", 8'(c0 + 1), 8'(n_clr));
      chk("run", 8'h01, {7'h0, run});
      chk("trims", tr[k], {4'h0, bgo, fgo, bg, fg});
    end
    rdchk(15'h0070, 8'h00);
    $display("test calibration done");
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // seventeen frames of about 326 clocks each fit well inside this span
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset();
    t_sel();
    t_cal();
    end_sim();
  end
endmodule
